/* ppom_pkg.sv */
// Functional notes
// RULE1 - Pull-up override enable set: pull-up follows override value, except bit 0 which reference select bit 0 forces off
// RULE2 - No pull-up override: pull-up on when {dir, out, pud} is 010
// RULE3 - Direction override enable set: driver enable follows override value
// RULE4 - No direction override: driver enable follows the pin direction bit
// RULE5 - Value override with driver on: pin driven by override value; bits 4, 6, 7 drive peripheral outputs, bit 5 value picks DO or t1 cmp B
// RULE6 - No value override with driver on: pin driven by output bit
// RULE7 - Toggle override enable inverts the pin output bit
// RULE8 - Input gate override enable set: digital input follows override value
// RULE9 - No input gate override: digital input follows awake or sleep state
// RULE10 - Alternate input taken before port synchronizer; receivers synchronise
// RULE11 - Peripherals generate their own override enable and value signals
// RULE12 - Strobes shared per port; clock, sleep, pud shared; overrides per pin
// RULE13 - Reference select bit 0 disables pull-up and driver on bit 0
// RULE14 - Port bits 0..7 feed pin change group 0 sources 0..7
// RULE15 - Outputs: t1 cmp B bit5, t1 cmp A bit6, t0 cmp B bit7, DO bit5, clk bit4
// RULE16 - Inputs: bit3 t0 count, bit4 t1 count, bit7 capture, bit6 serial in
// RULE17 - Writing one to input register bit toggles output bit
// RULE18 - Deep sleep clamps digital input low unless override or interrupt
// RULE19 - After reset all override enables are deasserted
package ppom_pkg;
   localparam int PPOM_WIDTH = 8;
   localparam int PPOM_BIT_REF = 0;
   localparam int PPOM_BIT_T0 = 3;
   localparam int PPOM_BIT_SCK = 4;
   localparam int PPOM_BIT_T1 = 4;
   localparam int PPOM_BIT_DO = 5;
   localparam int PPOM_BIT_CMP_OUT_B_TMR_ONE = 5;
   localparam int PPOM_BIT_CMP_OUT_A_TMR_ONE = 6;
   localparam int PPOM_BIT_SDI = 6;
   localparam int PPOM_BIT_CMP_OUT_B_TMR_ZERO = 7;
   localparam int PPOM_BIT_CAP = 7;
   localparam logic [2:0] PPOM_PULLUP_CODE = 3'h2;
   localparam logic [7:0] PPOM_RST_BYTE = 8'h00;
   localparam logic [31:0] PPOM_RST_WORD = 32'h0000_0000;
   localparam logic [11:0] PPOM_OFS_DIR = 12'h000;
   localparam logic [11:0] PPOM_OFS_OUT = 12'h004;
   localparam logic [11:0] PPOM_OFS_IN = 12'h008;
   localparam logic [11:0] PPOM_OFS_CTRL = 12'h00c;
   localparam logic [11:0] PPOM_OFS_PAD = 12'h010;
   localparam int PPOM_CTRL_PUD = 0;
   localparam int PPOM_CTRL_REFERENCE_SELECT_BIT0 = 1;
   typedef struct packed {
      logic [7:0] pullup_override_enable;
      logic [7:0] pullup_override_value;
      logic [7:0] direction_override_enable;
      logic [7:0] direction_override_value;
      logic [7:0] outval_override_enable;
      logic [7:0] outval_override_value;
      logic [7:0] toggle_override_enable;
      logic [7:0] input_gate_override_enable;
      logic [7:0] input_gate_override_value;
   } ppom_ovr_t;
   typedef struct packed {
      logic [7:0] pullup_on;
      logic [7:0] drive_en;
      logic [7:0] drive_val;
      logic [7:0] input_en;
   } ppom_pad_t;
endpackage

/* ppom_port.sv */
`timescale 1ns/1ps
`default_nettype none
module ppom_port
   import ppom_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ppom_ovr_t ovr_in,
   input wire logic deep_sleep,
   input wire logic [7:0] ext_irq_enable,
   input wire logic [7:0] pad_in,
   input wire logic cmp_out_b_tmr_one,
   input wire logic cmp_out_a_tmr_one,
   input wire logic cmp_out_b_tmr_zero,
   input wire logic serial_data_out,
   input wire logic serial_clock_three_wire,
   output ppom_pad_t pad_ctl,
   output logic [7:0] alt_pin_sense,
   output logic [7:0] pin_change_src,
   output logic count_src_zero,
   output logic count_src_one,
   output logic capture_in_tmr_one,
   output logic serial_data_in
);
   // ==========================================
   // Registers and override capture
   logic [7:0] pin_direction_bit;
   logic [7:0] pin_output_bit;
   logic [7:0] sync_stage;
   logic [7:0] pin_input_bit;
   logic global_pullup_disable;
   logic reference_select_bit0;
   ppom_ovr_t ovr;
   logic wr_acc;
   logic rd_acc;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;

   // Overrides registered so pad controls leave flip-flops
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ovr <= '0; // see RULE19
      end else begin
         ovr <= ovr_in; // see RULE11 see RULE12
      end
   end

   // ==========================================
   // Effective per-pin control
   logic [7:0] eff_out;
   logic [7:0] next_drive_en;
   logic [7:0] next_drive_val;
   logic [7:0] next_pullup;
   logic [7:0] next_input_en;
   always_comb begin
      eff_out = pin_output_bit ^ ovr.toggle_override_enable; // see RULE7
      for (int i = 0; i < PPOM_WIDTH; i++) begin
         next_drive_en[i] = ovr.direction_override_enable[i] ?
            ovr.direction_override_value[i] : pin_direction_bit[i]; // see RULE3 see RULE4
         next_drive_val[i] = ovr.outval_override_enable[i] ?
            ovr.outval_override_value[i] : eff_out[i]; // see RULE5 see RULE6
         next_pullup[i] = ovr.pullup_override_enable[i] ? ovr.pullup_override_value[i] :
            ({pin_direction_bit[i], eff_out[i], global_pullup_disable}
             == PPOM_PULLUP_CODE); // see RULE1 see RULE2
         next_input_en[i] = ovr.input_gate_override_enable[i] ?
            ovr.input_gate_override_value[i] :
            (!deep_sleep || ext_irq_enable[i]); // see RULE8 see RULE9 see RULE18
      end
      // Peripheral output routing
      if (ovr.outval_override_enable[PPOM_BIT_CMP_OUT_B_TMR_ONE]) begin
         next_drive_val[PPOM_BIT_CMP_OUT_B_TMR_ONE] = ovr.outval_override_value[PPOM_BIT_CMP_OUT_B_TMR_ONE] ?
            serial_data_out : cmp_out_b_tmr_one; // see RULE15
      end
      if (ovr.outval_override_enable[PPOM_BIT_CMP_OUT_A_TMR_ONE]) begin
         next_drive_val[PPOM_BIT_CMP_OUT_A_TMR_ONE] = cmp_out_a_tmr_one; // see RULE15
      end
      if (ovr.outval_override_enable[PPOM_BIT_CMP_OUT_B_TMR_ZERO]) begin
         next_drive_val[PPOM_BIT_CMP_OUT_B_TMR_ZERO] = cmp_out_b_tmr_zero; // see RULE15
      end
      if (ovr.outval_override_enable[PPOM_BIT_SCK]) begin
         next_drive_val[PPOM_BIT_SCK] = serial_clock_three_wire; // see RULE15
      end
      if (reference_select_bit0) begin
         next_pullup[PPOM_BIT_REF] = 1'b0; // see RULE13
         next_drive_en[PPOM_BIT_REF] = 1'b0; // see RULE13
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pad_ctl <= '0;
      end else begin
         pad_ctl.pullup_on <= next_pullup;
         pad_ctl.drive_en <= next_drive_en;
         pad_ctl.drive_val <= next_drive_val;
         pad_ctl.input_en <= next_input_en;
      end
   end

   // ==========================================
   // Alternate input delivery
   logic [7:0] gated_in;
   assign gated_in = pad_in & pad_ctl.input_en; // see RULE18
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         alt_pin_sense <= PPOM_RST_BYTE;
         pin_change_src <= PPOM_RST_BYTE;
         count_src_zero <= 1'b0;
         count_src_one <= 1'b0;
         capture_in_tmr_one <= 1'b0;
         serial_data_in <= 1'b0;
      end else begin
         alt_pin_sense <= gated_in; // see RULE10
         pin_change_src <= gated_in; // see RULE14
         count_src_zero <= gated_in[PPOM_BIT_T0]; // see RULE16
         count_src_one <= gated_in[PPOM_BIT_T1]; // see RULE16
         capture_in_tmr_one <= gated_in[PPOM_BIT_CAP]; // see RULE16
         serial_data_in <= gated_in[PPOM_BIT_SDI]; // see RULE16
      end
   end

   // Port synchronizer for software reads
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync_stage <= PPOM_RST_BYTE;
         pin_input_bit <= PPOM_RST_BYTE;
      end else begin
         sync_stage <= gated_in;
         pin_input_bit <= sync_stage;
      end
   end

   // ==========================================
   // APB register file
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_direction_bit <= PPOM_RST_BYTE;
      end else if (wr_acc && paddr == PPOM_OFS_DIR) begin
         pin_direction_bit <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_output_bit <= PPOM_RST_BYTE;
      end else if (wr_acc && paddr == PPOM_OFS_OUT) begin
         pin_output_bit <= pwdata[7:0];
      end else if (wr_acc && paddr == PPOM_OFS_IN) begin
         pin_output_bit <= pin_output_bit ^ pwdata[7:0]; // see RULE17
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         global_pullup_disable <= 1'b0;
         reference_select_bit0 <= 1'b0;
      end else if (wr_acc && paddr == PPOM_OFS_CTRL) begin
         global_pullup_disable <= pwdata[PPOM_CTRL_PUD];
         reference_select_bit0 <= pwdata[PPOM_CTRL_REFERENCE_SELECT_BIT0];
      end
   end

   logic [31:0] next_prdata;
   logic next_err;
   always_comb begin
      next_prdata = PPOM_RST_WORD;
      next_err = 1'b0;
      if (paddr == PPOM_OFS_DIR) begin
         next_prdata[7:0] = pin_direction_bit;
      end else if (paddr == PPOM_OFS_OUT) begin
         next_prdata[7:0] = pin_output_bit;
      end else if (paddr == PPOM_OFS_IN) begin
         next_prdata[7:0] = pin_input_bit;
      end else if (paddr == PPOM_OFS_CTRL) begin
         next_prdata[PPOM_CTRL_PUD] = global_pullup_disable;
         next_prdata[PPOM_CTRL_REFERENCE_SELECT_BIT0] = reference_select_bit0;
      end else if (paddr == PPOM_OFS_PAD) begin
         next_prdata = pad_ctl;
      end else begin
         next_err = 1'b1;
      end
   end

   // Zero-wait answer registered in the setup cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= PPOM_RST_WORD;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && next_err;
         prdata <= (psel && !penable && !pwrite) ? next_prdata : PPOM_RST_WORD;
      end
   end

   // ==========================================
   // Checks
   a_pullup_override: assert property (@(posedge clk) disable iff (!rst_n)
      ovr.pullup_override_enable[1] |=> pad_ctl.pullup_on[1] == $past(ovr.pullup_override_value[1]))
      else $error("pull-up override not honoured"); // see RULE1
   a_pullup_plain: assert property (@(posedge clk) disable iff (!rst_n)
      (!ovr.pullup_override_enable[2] && !ovr.toggle_override_enable[2])
      |=> pad_ctl.pullup_on[2] == $past({pin_direction_bit[2], pin_output_bit[2],
         global_pullup_disable} == 3'h2))
      else $error("plain pull-up wrong"); // see RULE2
   a_dir_override: assert property (@(posedge clk) disable iff (!rst_n)
      ovr.direction_override_enable[3] |=> pad_ctl.drive_en[3] == $past(ovr.direction_override_value[3]))
      else $error("direction override lost"); // see RULE3
   a_dir_plain: assert property (@(posedge clk) disable iff (!rst_n)
      !ovr.direction_override_enable[2] |=> pad_ctl.drive_en[2] == $past(pin_direction_bit[2]))
      else $error("driver not from direction bit"); // see RULE4
   a_val_plain: assert property (@(posedge clk) disable iff (!rst_n)
      !ovr.outval_override_enable[1] |=> pad_ctl.drive_val[1] == $past(eff_out[1]))
      else $error("output value wrong"); // see RULE6
   a_toggle_inv: assert property (@(posedge clk) disable iff (!rst_n)
      (ovr.toggle_override_enable[1] && !ovr.outval_override_enable[1])
      |=> pad_ctl.drive_val[1] != $past(pin_output_bit[1]))
      else $error("toggle override not inverting"); // see RULE7
   a_input_gate: assert property (@(posedge clk) disable iff (!rst_n)
      ovr.input_gate_override_enable[4] |=> pad_ctl.input_en[4] == $past(ovr.input_gate_override_value[4]))
      else $error("input gate override lost"); // see RULE8
   a_sleep_clamp: assert property (@(posedge clk) disable iff (!rst_n)
      (deep_sleep && !ovr.input_gate_override_enable[5] && !ext_irq_enable[5])
      |=> !pad_ctl.input_en[5])
      else $error("input not clamped in sleep"); // see RULE9
   a_ref_disable: assert property (@(posedge clk) disable iff (!rst_n)
      reference_select_bit0 |=> !pad_ctl.pullup_on[0] && !pad_ctl.drive_en[0])
      else $error("reference pin still driven"); // see RULE13
   a_pin_toggle: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_acc && paddr == PPOM_OFS_IN) |=> pin_output_bit == ($past(pin_output_bit) ^ $past(pwdata[7:0])))
      else $error("pin toggle write failed"); // see RULE17
   a_irq_route: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> pin_change_src == $past(gated_in))
      else $error("pin change source wrong"); // see RULE14

   // ==========================================
   // Per-pin override and routing checks
   a_pullup_ovr_six: assert property (@(posedge clk) disable iff (!rst_n)
      ovr.pullup_override_enable[6]
      |=> pad_ctl.pullup_on[6] == $past(ovr.pullup_override_value[6]))
      else $error("pull-up override lost on bit 6"); // see RULE1

   a_pullup_plain_three: assert property (@(posedge clk) disable iff (!rst_n)
      !ovr.pullup_override_enable[3] |=> pad_ctl.pullup_on[3] ==
         $past({pin_direction_bit[3], eff_out[3], global_pullup_disable} == PPOM_PULLUP_CODE))
      else $error("plain pull-up wrong on bit 3"); // see RULE2

   a_pud_kills_pullup: assert property (@(posedge clk) disable iff (!rst_n)
      (global_pullup_disable && !ovr.pullup_override_enable[2])
      |=> !pad_ctl.pullup_on[2])
      else $error("pull-up on despite global disable"); // see RULE2

   a_dir_ovr_six: assert property (@(posedge clk) disable iff (!rst_n)
      ovr.direction_override_enable[6]
      |=> pad_ctl.drive_en[6] == $past(ovr.direction_override_value[6]))
      else $error("direction override lost on bit 6"); // see RULE3

   a_dir_plain_seven: assert property (@(posedge clk) disable iff (!rst_n)
      !ovr.direction_override_enable[7]
      |=> pad_ctl.drive_en[7] == $past(pin_direction_bit[7]))
      else $error("driver not from direction bit 7"); // see RULE4

   a_val_ovr_two: assert property (@(posedge clk) disable iff (!rst_n)
      ovr.outval_override_enable[2]
      |=> pad_ctl.drive_val[2] == $past(ovr.outval_override_value[2]))
      else $error("value override lost on bit 2"); // see RULE5

   a_val_ovr_one: assert property (@(posedge clk) disable iff (!rst_n)
      ovr.outval_override_enable[1]
      |=> pad_ctl.drive_val[1] == $past(ovr.outval_override_value[1]))
      else $error("value override lost on bit 1"); // see RULE5

   a_val_plain_three: assert property (@(posedge clk) disable iff (!rst_n)
      !ovr.outval_override_enable[3] |=> pad_ctl.drive_val[3] ==
         $past(pin_output_bit[3] ^ ovr.toggle_override_enable[3]))
      else $error("output value wrong on bit 3"); // see RULE6

   a_toggle_three: assert property (@(posedge clk) disable iff (!rst_n)
      (ovr.toggle_override_enable[3] && !ovr.outval_override_enable[3])
      |=> pad_ctl.drive_val[3] != $past(pin_output_bit[3]))
      else $error("toggle override not inverting bit 3"); // see RULE7

   a_gate_ovr_zero: assert property (@(posedge clk) disable iff (!rst_n)
      ovr.input_gate_override_enable[0]
      |=> pad_ctl.input_en[0] == $past(ovr.input_gate_override_value[0]))
      else $error("input gate override lost on bit 0"); // see RULE8

   a_gate_awake: assert property (@(posedge clk) disable iff (!rst_n)
      (!deep_sleep && !ovr.input_gate_override_enable[6])
      |=> pad_ctl.input_en[6])
      else $error("input disabled while awake"); // see RULE9

   a_irq_keeps_input: assert property (@(posedge clk) disable iff (!rst_n)
      (deep_sleep && ext_irq_enable[6] && !ovr.input_gate_override_enable[6])
      |=> pad_ctl.input_en[6])
      else $error("interrupt pin clamped in sleep"); // see RULE18

   a_alt_sense: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1
      |=> alt_pin_sense == $past(gated_in))
      else $error("alternate input path wrong"); // see RULE10

   a_noref_drive: assert property (@(posedge clk) disable iff (!rst_n)
      (!reference_select_bit0 && !ovr.direction_override_enable[0])
      |=> pad_ctl.drive_en[0] == $past(pin_direction_bit[0]))
      else $error("bit 0 driver wrong without reference"); // see RULE13

   a_route_cmp_a: assert property (@(posedge clk) disable iff (!rst_n)
      ovr.outval_override_enable[PPOM_BIT_CMP_OUT_A_TMR_ONE]
      |=> pad_ctl.drive_val[PPOM_BIT_CMP_OUT_A_TMR_ONE] == $past(cmp_out_a_tmr_one))
      else $error("compare A not routed"); // see RULE15

   a_route_cmp_b0: assert property (@(posedge clk) disable iff (!rst_n)
      ovr.outval_override_enable[PPOM_BIT_CMP_OUT_B_TMR_ZERO]
      |=> pad_ctl.drive_val[PPOM_BIT_CMP_OUT_B_TMR_ZERO] == $past(cmp_out_b_tmr_zero))
      else $error("timer zero compare B not routed"); // see RULE15

   a_route_sck: assert property (@(posedge clk) disable iff (!rst_n)
      ovr.outval_override_enable[PPOM_BIT_SCK]
      |=> pad_ctl.drive_val[PPOM_BIT_SCK] == $past(serial_clock_three_wire))
      else $error("serial clock not routed"); // see RULE15

   a_route_do: assert property (@(posedge clk) disable iff (!rst_n)
      (ovr.outval_override_enable[PPOM_BIT_DO] && ovr.outval_override_value[PPOM_BIT_DO])
      |=> pad_ctl.drive_val[PPOM_BIT_DO] == $past(serial_data_out))
      else $error("serial data out not routed"); // see RULE15

   a_route_cmp_b1: assert property (@(posedge clk) disable iff (!rst_n)
      (ovr.outval_override_enable[PPOM_BIT_CMP_OUT_B_TMR_ONE] && !ovr.outval_override_value[PPOM_BIT_CMP_OUT_B_TMR_ONE])
      |=> pad_ctl.drive_val[PPOM_BIT_CMP_OUT_B_TMR_ONE] == $past(cmp_out_b_tmr_one))
      else $error("timer one compare B not routed"); // see RULE15

   a_count_route: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> {count_src_zero, count_src_one, capture_in_tmr_one, serial_data_in} ==
         $past({gated_in[PPOM_BIT_T0], gated_in[PPOM_BIT_T1], gated_in[PPOM_BIT_CAP], gated_in[PPOM_BIT_SDI]}))
      else $error("input routing wrong"); // see RULE16

   a_dir_write: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_acc && paddr == PPOM_OFS_DIR)
      |=> pin_direction_bit == $past(pwdata[7:0]))
      else $error("direction write lost"); // see RULE12

   a_ovr_reset: assert property (@(posedge clk)
      !rst_n
      |=> ovr == '0)
      else $error("overrides not cleared by reset"); // see RULE19
endmodule
`default_nettype wire

/* ppom_periph_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ppom_periph_model
   import ppom_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire ppom_ovr_t req,
   input wire logic [4:0] fn_req,
   input wire logic [7:0] alt_pin_sense,
   output ppom_ovr_t ovr,
   output logic [4:0] fn,
   output logic [7:0] sense_sync
);
   logic [7:0] sense_meta;
   // =====================================
   // Peripherals register their own overrides
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ovr <= '0;
         fn <= '0;
      end else begin
         ovr <= req;
         fn <= fn_req;
      end
   end
   // =====================================
   // Own synchroniser on the alternate input
   always_ff @(posedge clk) begin
      sense_meta <= alt_pin_sense;
      sense_sync <= sense_meta;
   end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb import ppom_pkg::*;;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, deep_sleep, er;
   logic c0, c1, cap, sdi;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] ext_irq_enable, pad_in, alt_pin_sense, pin_change_src;
   logic [4:0] fn_req, fn;
   logic [7:0] ex [5];
   ppom_ovr_t req, ovr;
   ppom_pad_t pad_ctl;
   int fails, check_count;
   ppom_periph_model u_ppom_periph_model(.clk, .rst_n, .req, .fn_req, .alt_pin_sense,
      .ovr, .fn, .sense_sync());
   ppom_port u_ppom_port(.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .ovr_in(ovr), .deep_sleep, .ext_irq_enable, .pad_in,
      .cmp_out_b_tmr_one(fn[0]), .cmp_out_a_tmr_one(fn[1]), .cmp_out_b_tmr_zero(fn[2]),
      .serial_data_out(fn[3]), .serial_clock_three_wire(fn[4]), .pad_ctl,
      .alt_pin_sense, .pin_change_src, .count_src_zero(c0), .count_src_one(c1),
      .capture_in_tmr_one(cap), .serial_data_in(sdi));
   // =====================================
   // Clock and helpers
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic close_out();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fails++;
         close_out();
      end
   endtask
   task automatic settle();
      repeat (6) @(posedge clk);
   endtask
   // =====================================
   // Scenarios
   task automatic t_regs();
      apb(1, PPOM_OFS_DIR, 8'hf0);
      apb(1, PPOM_OFS_OUT, 8'h3c);
      settle();
      chk("pullup", 8'h0c, pad_ctl.pullup_on);
      chk("drive_en", 8'hf0, pad_ctl.drive_en);
      chk("drive_val", 8'h30, pad_ctl.drive_val & pad_ctl.drive_en);
      apb(1, PPOM_OFS_CTRL, 8'h01);
      settle();
      chk("pullup_pud", 8'h00, pad_ctl.pullup_on);
      apb(0, PPOM_OFS_CTRL, 8'h00);
      chk("ctrl_rd", 32'h1, rd);
      apb(0, PPOM_OFS_DIR, 8'h00);
      chk("dir_rd", 32'hf0, rd);
   endtask
   task automatic t_refs();
      apb(1, PPOM_OFS_DIR, 8'h00);
      apb(1, PPOM_OFS_OUT, 8'h01);
      apb(1, PPOM_OFS_CTRL, 8'h02);
      settle();
      chk("ref_pullup", 8'h00, pad_ctl.pullup_on);
      apb(1, PPOM_OFS_DIR, 8'h01);
      settle();
      chk("ref_drive", 8'h00, pad_ctl.drive_en);
      apb(1, PPOM_OFS_CTRL, 8'h00);
      settle();
      chk("noref_drive", 8'h01, pad_ctl.drive_en);
   endtask
   task automatic t_ovr();
      apb(1, PPOM_OFS_DIR, 8'h0f);
      apb(1, PPOM_OFS_OUT, 8'h00);
      @(posedge clk);
      // Fields: pu en/val, dir en/val, out en/val, toggle, gate en/val
      req <= {8'hff, 8'ha5, 8'hff, 8'h3c, 8'h0f, 8'h05, 8'h00, 8'h0f, 8'h05};
      deep_sleep <= 1'b1;
      ext_irq_enable <= 8'h10;
      pad_in <= 8'hff;
      settle();
      chk("ovr_pullup", 8'ha5, pad_ctl.pullup_on);
      chk("ovr_drive", 8'h3c, pad_ctl.drive_en);
      chk("ovr_val", 8'h04, pad_ctl.drive_val & 8'h0c);
      chk("gate_sleep", 8'h15, pad_ctl.input_en);
      chk("sense_sleep", 8'h15, alt_pin_sense);
      deep_sleep <= 1'b0;
      settle();
      chk("gate_awake", 8'hf5, pad_ctl.input_en);
      chk("pcint", 8'hf5, pin_change_src);
      req <= 72'h0f << 16;
      settle();
      chk("toggle", 8'h0f, pad_ctl.drive_val & pad_ctl.drive_en);
   endtask
   task automatic t_route();
      @(posedge clk);
      req <= '0;
      for (int i = 0; i < 8; i++) begin
         pad_in <= 8'h01 << i;
         settle();
         chk("pcint_bit", 8'h01 << i, pin_change_src);
         chk("in_route", {i == 3, i == 4, i == 7, i == 6}, {c0, c1, cap, sdi});
      end
      apb(0, PPOM_OFS_IN, 8'h00);
      chk("pin_rd", 32'h80, rd);
      apb(0, PPOM_OFS_PAD, 8'h00);
      chk("pad_rd", 32'h000f00ff, rd);
   endtask
   task automatic t_outs();
      ex = '{8'h20, 8'h40, 8'h80, 8'h20, 8'h10};
      apb(1, PPOM_OFS_DIR, 8'hf0);
      for (int k = 0; k < 5; k++) begin
         req <= {32'h0, 8'hf0, (k == 3) ? 8'h20 : 8'h00, 24'h0};
         fn_req <= 5'h01 << k;
         settle();
         chk("out_route", ex[k], pad_ctl.drive_val & 8'hf0);
      end
   endtask
   task automatic t_misc();
      apb(1, PPOM_OFS_OUT, 8'h00);
      apb(1, PPOM_OFS_IN, 8'h81);
      apb(0, PPOM_OFS_OUT, 8'h00);
      chk("pin_toggle", 32'h81, rd);
      apb(1, PPOM_OFS_IN, 8'h01);
      apb(0, PPOM_OFS_OUT, 8'h00);
      chk("pin_toggle2", 32'h80, rd);
      apb(0, 12'h040, 8'h00);
      chk("err_rd", 1'b1, er);
      chk("err_data", 32'h0, rd);
      apb(1, 12'h040, 8'hff);
      chk("err_wr", 1'b1, er);
   endtask
   // =====================================
   // Main sequence
   initial begin
      {rst_n, psel, penable, pwrite, deep_sleep} = '0;
      {paddr, pwdata, ext_irq_enable, pad_in, fn_req} = '0;
      req = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      chk("pad_reset", 32'h0, pad_ctl);
      t_regs();
      t_refs();
      t_ovr();
      t_route();
      t_outs();
      t_misc();
      close_out();
   end
endmodule
`default_nettype wire
